// file: tws_consts.svh
// Constants for the tape write word serializer: field positions, register offsets, timing counts.
// Assumes a 250 MHz core clock; included by bare name from the design files.
// Function
// - Mixer byte comes from top six shift bits.
// - First pulse shifts register left one byte.
// - Without setup, first pulse loads data into low bits.
// - Fourth pulse loads shift register from half A.
// - Fifth pulse moves half B into half A.
// - Fifth pulse stores shift into B, then sixth.
// - Sixth pulse toggles counter; raises word request only when toggle was set.
// - Strobes four to six repeat one to three.
// - After sixth strobe clear shift, need word.
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH
`define TWS_WORD_W        36
`define TWS_HALF_W        18
`define TWS_BYTE_W        6
`define TWS_BYTE_TOP_LSB  12
`define TWS_DELAY_NS      1000
`define TWS_CLK_MHZ       250
`define TWS_DELAY_CYC     ((`TWS_DELAY_NS * `TWS_CLK_MHZ) / 1000)
`define TWS_CNT_W         10
`define TWS_INT_STAT_OFS  12'h000
`define TWS_INT_MASK_OFS  12'h004
`define TWS_CTRL_OFS      12'h008
`define TWS_STATE_OFS     12'h00C
`define TWS_INT_REQ_BIT   0
`define TWS_INT_WORD_BIT  1
`define TWS_INT_BYTE_BIT  2
`define TWS_INT_W         3
`endif

// file: tws_pkg.sv
// Types shared by the tape write word serializer.
// Assumes tws_consts.svh supplies the numeric constants.
`include "tws_consts.svh"
package tws_pkg;
    // Pulse sequencer phases.
    typedef enum logic [3:0] {
        TWS_IDLE, TWS_WAIT_STROBE, TWS_DLY_2, TWS_DLY_3, TWS_DLY_4,
        TWS_DLY_5, TWS_DLY_6, TWS_WAIT_WORD, TWS_DLY_LOAD
    } tws_state_e;
endpackage

// file: tws_delay.sv
// One-shot delay timer producing a one-cycle done pulse after a fixed count.
// Assumes the start pulse is not repeated while a count is running.
`timescale 1ns/1ns
`include "tws_consts.svh"
module tws_delay (
    // Clock and reset.
    input  wire logic i_core_clk,
    input  wire logic i_sys_rst,
    // Control.
    input  wire logic i_start,
    output logic      o_done
);
    logic [`TWS_CNT_W-1:0] cnt_ff;
    logic                  run_ff;

    // Count down from the full delay; done fires on the last cycle.
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                cnt_ff <= `TWS_CNT_W'(`TWS_DELAY_CYC - 1);
                run_ff <= 1'b1;
            end else if (run_ff) begin
                if (cnt_ff == '0) begin
                    run_ff <= 1'b0;
                    o_done <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff - 1'b1;
                end
            end
        end
    end
endmodule

// file: tws_serializer.sv
// Write-forward word serializer: buffer halves, shift register and pulse sequencer.
// Assumes APB master on the core clock and tape byte strobes synchronous to it.
`timescale 1ns/1ns
`include "tws_consts.svh"
module tws_serializer
    import tws_pkg::*;
(
    // Clock and reset.
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    // APB slave.
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Processor word delivery.
    input  wire logic        i_data_out_transfer,
    input  wire logic [35:0] i_word,
    output logic             o_word_request_flag,
    // Tape side.
    input  wire logic        i_tape_byte_strobe,
    input  wire logic [5:0]  i_rw_data,
    output logic      [5:0]  o_mixer_byte,
    output logic             o_forward_write_gate,
    // Interrupt.
    output logic             o_irq
);
    tws_state_e                 state_ff;
    logic [`TWS_HALF_W-1:0]     word_shift_reg_ff;
    logic [`TWS_HALF_W-1:0]     buffer_half_a_ff;
    logic [`TWS_HALF_W-1:0]     buffer_half_b_ff;
    logic [1:0]                 byte_cnt_ff;
    logic                       half_word_toggle_ff;
    logic                       word_need_flag_ff;
    logic                       word_request_flag_ff;
    logic                       write_setup_flag_ff;
    logic                       reverse_swap_flag_ff;
    logic                       enable_ff;
    logic [`TWS_INT_W-1:0]      int_stat_ff;
    logic [`TWS_INT_W-1:0]      int_mask_ff;
    logic [`TWS_INT_W-1:0]      nxt_int_set;
    logic                       dly_start;
    logic                       dly_done;
    logic                       pulse_1;
    logic                       pulse_4;
    logic                       pulse_5;
    logic                       pulse_6;
    logic                       shift_clear_pulse;
    logic                       req_raise;
    logic                       word_take;
    logic                       apb_wr;
    logic                       apb_rd;

    // Bus transfers complete in their first access cycle, never stalled.
    assign apb_wr    = i_psel && i_penable && i_pwrite;
    assign apb_rd    = i_psel && i_penable && !i_pwrite;
    assign o_pready  = 1'b1;
    assign o_pslverr = 1'b0;

    // A word is accepted only while the sequencer is waiting for one.
    assign word_take = i_data_out_transfer && word_need_flag_ff;

    // Timing pulses decoded from the sequencer phase and the delay timer.
    // A strobe counts only while the gate shown to the tape side is up.
    assign pulse_1 = (state_ff == TWS_WAIT_STROBE) && o_forward_write_gate && i_tape_byte_strobe;
    assign shift_clear_pulse = dly_done && (state_ff == TWS_DLY_3);
    assign pulse_4 = dly_done && (state_ff == TWS_DLY_4);
    assign pulse_5 = dly_done && (state_ff == TWS_DLY_5);
    assign pulse_6 = dly_done && (state_ff == TWS_DLY_6) && !reverse_swap_flag_ff;
    // Besides enable from idle, only the sixth pulse that ends the low-half reload asks the processor for a word.
    assign req_raise = pulse_6 && half_word_toggle_ff;

    // Every phase that waits on the timer restarts it once when entered.
    // A stray restart would fire later inside an unrelated phase, so none is issued.
    assign dly_start = pulse_1
                       || (dly_done && (state_ff == TWS_DLY_2) && (byte_cnt_ff == 2'h2))
                       || (shift_clear_pulse && half_word_toggle_ff) || pulse_4 || pulse_5
                       || (dly_done && (state_ff == TWS_DLY_LOAD)) || word_take;

    tws_delay u_delay (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_start    (dly_start),
        .o_done     (dly_done)
    );

    // Sequencer: strobes of the first and second bytes of a half skip the reload.
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_ff    <= TWS_IDLE;
            byte_cnt_ff <= 2'h0;
        end else begin
            case (state_ff)
                TWS_IDLE: begin
                    if (enable_ff) begin
                        state_ff <= TWS_WAIT_WORD;
                    end
                end
                TWS_WAIT_STROBE: begin
                    if (!enable_ff) begin
                        state_ff <= TWS_IDLE;
                    end else if (pulse_1) begin
                        state_ff <= TWS_DLY_2;
                    end
                end
                TWS_DLY_2: begin
                    if (dly_done) begin
                        // Only the third byte of a half runs the reload chain.
                        if (byte_cnt_ff == 2'h2) begin
                            state_ff    <= TWS_DLY_3;
                            byte_cnt_ff <= 2'h0;
                        end else begin
                            state_ff    <= TWS_WAIT_STROBE;
                            byte_cnt_ff <= byte_cnt_ff + 2'h1;
                        end
                    end
                end
                TWS_DLY_3: begin
                    if (dly_done) begin
                        // A clear toggle means the low half went out: the word is spent.
                        state_ff <= half_word_toggle_ff ? TWS_DLY_4 : TWS_WAIT_WORD;
                    end
                end
                TWS_DLY_4: begin
                    if (dly_done) begin
                        state_ff <= TWS_DLY_5;
                    end
                end
                TWS_DLY_5: begin
                    if (dly_done) begin
                        state_ff <= TWS_DLY_6;
                    end
                end
                TWS_DLY_6: begin
                    if (pulse_6) begin
                        state_ff <= TWS_WAIT_STROBE;
                    end
                end
                TWS_WAIT_WORD: begin
                    if (word_take) begin
                        state_ff <= TWS_DLY_LOAD;
                    end
                end
                TWS_DLY_LOAD: begin
                    if (dly_done) begin
                        state_ff <= TWS_DLY_5;
                    end
                end
                default: begin
                    state_ff <= TWS_IDLE;
                end
            endcase
        end
    end

    // Shift register: clear, load from half A, or shift a byte and refill.
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            word_shift_reg_ff <= '0;
        end else if (shift_clear_pulse) begin
            word_shift_reg_ff <= '0;
        end else if (pulse_4 || (dly_done && state_ff == TWS_DLY_LOAD)) begin
            word_shift_reg_ff <= buffer_half_a_ff;
        end else if (pulse_1) begin
            // Shift and refill act the same for every strobe of the word.
            word_shift_reg_ff <= {word_shift_reg_ff[`TWS_BYTE_TOP_LSB-1:0],
                                  write_setup_flag_ff ? 6'h00 : i_rw_data};
        end
    end

    // Buffer halves: fresh word on delivery, half B into half A on the fifth pulse.
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            buffer_half_a_ff <= '0;
            buffer_half_b_ff <= '0;
        end else if (word_take) begin
            buffer_half_a_ff <= i_word[`TWS_WORD_W-1:`TWS_HALF_W];
            buffer_half_b_ff <= i_word[`TWS_HALF_W-1:0];
        end else if (pulse_5) begin
            buffer_half_a_ff <= buffer_half_b_ff;
            buffer_half_b_ff <= word_shift_reg_ff;
        end
    end

    // Half-word toggle flips on each sixth pulse; reset on a new word.
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || word_take) begin
            half_word_toggle_ff <= 1'b0;
        end else if (pulse_6) begin
            half_word_toggle_ff <= !half_word_toggle_ff;
        end
    end

    // Word need rises when the word is spent and drops when one arrives.
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            word_need_flag_ff <= 1'b0;
        end else if ((state_ff == TWS_IDLE && enable_ff)
                     || (dly_done && state_ff == TWS_DLY_3 && !half_word_toggle_ff)) begin
            word_need_flag_ff <= 1'b1;
        end else if (word_take) begin
            word_need_flag_ff <= 1'b0;
        end
    end

    // Word request: set by the sixth pulse, held until delivery; set wins.
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            word_request_flag_ff <= 1'b0;
        end else if (req_raise || (state_ff == TWS_IDLE && enable_ff)) begin
            word_request_flag_ff <= 1'b1;
        end else if (word_take) begin
            word_request_flag_ff <= 1'b0;
        end
    end

    // Mixer byte is registered so it stays stable through the tape strobe.
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_mixer_byte         <= 6'h00;
            o_forward_write_gate <= 1'b0;
        end else begin
            o_mixer_byte <= word_shift_reg_ff[`TWS_HALF_W-1:`TWS_BYTE_TOP_LSB];
            // Dropped on the taken strobe so a second strobe cannot be offered a stale gate.
            o_forward_write_gate <= (state_ff == TWS_WAIT_STROBE) && !pulse_1
                                    && enable_ff;
        end
    end

    // Control register: enable, write setup and swap are software-driven here.
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            enable_ff            <= 1'b0;
            write_setup_flag_ff  <= 1'b0;
            reverse_swap_flag_ff <= 1'b0;
            int_mask_ff          <= '0;
        end else if (apb_wr && i_paddr == `TWS_CTRL_OFS) begin
            enable_ff            <= i_pwdata[0];
            write_setup_flag_ff  <= i_pwdata[1];
            reverse_swap_flag_ff <= i_pwdata[2];
        end else if (apb_wr && i_paddr == `TWS_INT_MASK_OFS) begin
            int_mask_ff <= i_pwdata[`TWS_INT_W-1:0];
        end
    end

    // Sticky events: request raised, word accepted, byte strobe taken.
    always_comb begin
        nxt_int_set = '0;
        nxt_int_set[`TWS_INT_REQ_BIT]  = req_raise;
        nxt_int_set[`TWS_INT_WORD_BIT] = word_take;
        nxt_int_set[`TWS_INT_BYTE_BIT] = pulse_1;
    end

    // Write one to clear; a simultaneous event keeps its bit set.
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            int_stat_ff <= '0;
        end else if (apb_wr && i_paddr == `TWS_INT_STAT_OFS) begin
            int_stat_ff <= (int_stat_ff & ~i_pwdata[`TWS_INT_W-1:0]) | nxt_int_set;
        end else begin
            int_stat_ff <= int_stat_ff | nxt_int_set;
        end
    end

    // Read data registered on the setup cycle, ready in the access cycle; unmapped offsets read zero.
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_prdata <= 32'h0000_0000;
            o_irq    <= 1'b0;
        end else begin
            o_irq <= |(int_stat_ff & int_mask_ff);
            if (i_psel && !i_penable && !i_pwrite) begin
                case (i_paddr)
                    `TWS_INT_STAT_OFS: o_prdata <= {29'h0, int_stat_ff};
                    `TWS_INT_MASK_OFS: o_prdata <= {29'h0, int_mask_ff};
                    `TWS_CTRL_OFS: o_prdata <= {29'h0, reverse_swap_flag_ff,
                                                write_setup_flag_ff, enable_ff};
                    `TWS_STATE_OFS: o_prdata <= {23'h0, word_need_flag_ff,
                                                 word_request_flag_ff, half_word_toggle_ff,
                                                 byte_cnt_ff, state_ff};
                    default: o_prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign o_word_request_flag = word_request_flag_ff;

    // The read strobe is only decoded for completeness of the bus view.
    logic unused_rd;
    assign unused_rd = apb_rd;
endmodule

// file: tws_serializer_monitor.sv
// Checker for the serializer ports: bus answers, word handshake, byte pacing.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ns
module tws_serializer_monitor (
    input wire logic        i_core_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        i_data_out_transfer,
    input wire logic        o_word_request_flag,
    input wire logic        i_tape_byte_strobe,
    input wire logic        o_forward_write_gate
);
    logic [9:0] gap_ff;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    // Cycles since the last taken strobe; it saturates so idle time reads as long.
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            gap_ff <= 10'h3FF;
        end else if (o_forward_write_gate && i_tape_byte_strobe) begin
            gap_ff <= 10'h000;
        end else if (gap_ff != 10'h3FF) begin
            gap_ff <= gap_ff + 10'h001;
        end
    end
    bus_ready_a: assert property (i_psel && i_penable |-> o_pready && !o_pslverr)
        else $error("bus access not answered at once");
    unmapped_zero_a: assert property (i_psel && i_penable && !i_pwrite && i_paddr >= 12'h010
        |-> o_prdata == 32'h0) else $error("unmapped read not zero");
    req_release_a: assert property ($fell(o_word_request_flag) |-> $past(i_data_out_transfer))
        else $error("request dropped without a transfer");
    req_hold_a: assert property (o_word_request_flag && !i_data_out_transfer |=> o_word_request_flag)
        else $error("request dropped early");
    req_gap_a: assert property ($rose(o_word_request_flag) |-> !o_forward_write_gate && gap_ff >= 10'd750)
        else $error("request raised too soon after a strobe");
    strobe_take_a: assert property (o_forward_write_gate && i_tape_byte_strobe |=> !o_forward_write_gate [*8])
        else $error("gate stayed up after a strobe");
    gate_hold_a: assert property (o_forward_write_gate && !i_tape_byte_strobe |=> o_forward_write_gate)
        else $error("gate dropped without a strobe");
    pulse_gap_a: assert property ($rose(o_forward_write_gate) |-> gap_ff >= 10'd248)
        else $error("byte gate reopened before the delay");
endmodule

// file: tws_host_model.sv
// Host and tape model: hands words over on request and strobes bytes out of the mixer.
// Assumes the serializer runs on the same core clock.
`timescale 1ns/1ns
module tws_host_model (
    // Clock and reset.
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    // Serializer outputs and bench controls.
    input  wire logic        i_word_request_flag,
    input  wire logic        i_forward_write_gate,
    input  wire logic [5:0]  i_mixer_byte,
    input  wire logic [35:0] i_next_word,
    input  wire logic [5:0]  i_lag,
    // Drives into the serializer and reports to the bench.
    output logic             o_data_out_transfer,
    output logic      [35:0] o_word,
    output logic             o_tape_byte_strobe,
    output logic      [5:0]  o_rw_data,
    output logic             o_took,
    output logic             o_byte_seen,
    output logic      [5:0]  o_byte
);
    // Quiet values at time zero so no design input starts unknown.
    initial begin
        o_data_out_transfer = 1'b0;
        o_word = 36'h0;
        o_tape_byte_strobe = 1'b0;
        o_rw_data = 6'h0;
        o_took = 1'b0;
        o_byte_seen = 1'b0;
        o_byte = 6'h0;
    end
    // Pulses repeat while the request stands, since early ones may be ignored.
    always begin
        @(posedge i_core_clk);
        o_took <= 1'b0;
        if (!i_sys_rst && i_word_request_flag) begin
            repeat (i_lag) @(posedge i_core_clk);
            while (i_word_request_flag) begin
                o_data_out_transfer <= 1'b1;
                o_word <= i_next_word;
                @(posedge i_core_clk);
                o_data_out_transfer <= 1'b0;
                o_word <= ~i_next_word; // Released bus shows no stale word.
                repeat (3) @(posedge i_core_clk);
            end
            o_took <= 1'b1;
        end
    end
    // Strobe after a random lag and take the mixer byte on the next edge, as the strobe drops.
    always begin
        @(posedge i_core_clk);
        if (!i_sys_rst && i_forward_write_gate) begin
            repeat (i_lag + 2) @(posedge i_core_clk);
            o_tape_byte_strobe <= 1'b1;
            o_rw_data <= i_next_word[5:0] ^ i_lag;
            @(posedge i_core_clk);
            o_tape_byte_strobe <= 1'b0;
            o_byte <= i_mixer_byte;
            o_byte_seen <= 1'b1;
            @(posedge i_core_clk);
            o_byte_seen <= 1'b0;
        end
    end
endmodule

// file: tws_serializer_tb_top.sv
// Bench for the write word serializer: registers, a word stream and the interrupt.
// Assumes the host model answers requests and gates with random lag.
`timescale 1ns/1ns
module tws_serializer_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic [35:0] word, cur_word;
    logic [5:0]  rw, mix, byte_v, lag;
    logic        pready, pslverr, dot, req, stb, gate, irq, took, seen;
    logic [5:0]  exp_q[$];
    int          bad_count = 0;
    int          checks_done = 0;
    int          got = 0;
    always #2 clk = ~clk;
    tws_serializer tws_serializer_i (.i_core_clk(clk), .i_sys_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_data_out_transfer(dot), .i_word(word), .o_word_request_flag(req),
        .i_tape_byte_strobe(stb), .i_rw_data(rw), .o_mixer_byte(mix),
        .o_forward_write_gate(gate), .o_irq(irq));
    tws_host_model tws_host_model_i (.i_core_clk(clk), .i_sys_rst(rst),
        .i_word_request_flag(req), .i_forward_write_gate(gate), .i_mixer_byte(mix),
        .i_next_word(cur_word), .i_lag(lag), .o_data_out_transfer(dot), .o_word(word),
        .o_tape_byte_strobe(stb), .o_rw_data(rw), .o_took(took), .o_byte_seen(seen),
        .o_byte(byte_v));
    task automatic chk(input string nm, input logic [35:0] seen_v, input logic [35:0] exp_v);
        checks_done++;
        if (seen_v !== exp_v) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp_v, seen_v);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // One bus transfer; the request is held until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            finish_test();
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Reference model: each taken word yields six bytes, high half first.
    always @(posedge clk) begin
        if (seen) begin
            chk("mixer byte", 36'(byte_v), exp_q.size() ? 36'(exp_q.pop_front()) : 36'hX);
            lag <= 6'($urandom_range(40));
            got++;
        end
        if (took) begin
            for (int i = 5; i >= 0; i--) exp_q.push_back(cur_word[i*6 +: 6]);
            cur_word <= 36'({$urandom(), $urandom()});
        end
    end
    initial begin
        void'($urandom(45));
        cur_word = 36'({$urandom(), $urandom()});
        lag = 6'h03;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 12'h008, 32'h0, rd);
        chk("ctrl reset", 36'(rd), 36'h0);
        apb(1'b1, 12'h010, 32'hFFFFFFFF, rd);
        apb(1'b0, 12'h010, 32'h0, rd);
        chk("unmapped", 36'(rd), 36'h0);
        apb(1'b0, 12'h004, 32'h0, rd);
        chk("mask reset", 36'(rd), 36'h0);
        apb(1'b1, 12'h008, 32'h00000001, rd);
        for (int n = 0; n < 40000 && got < 18; n++) @(posedge clk);
        if (got < 18) begin
            bad_count++;
            finish_test();
        end
        // Events are sticky but masked, so the interrupt stays low until unmasked.
        apb(1'b0, 12'h000, 32'h0, rd);
        chk("status", 36'(rd[2:0]), 36'h7);
        chk("irq masked", 36'(irq), 36'h0);
        apb(1'b1, 12'h004, 32'h00000004, rd);
        apb(1'b0, 12'h004, 32'h0, rd);
        chk("mask", 36'(rd), 36'h4);
        chk("irq open", 36'(irq), 36'h1);
        apb(1'b1, 12'h000, 32'h00000007, rd);
        apb(1'b1, 12'h004, 32'h00000001, rd);
        repeat (2) @(posedge clk);
        chk("irq cleared", 36'(irq), 36'h0);
        apb(1'b0, 12'h000, 32'h0, rd);
        chk("status cleared", 36'(rd[0]), 36'h0);
        finish_test();
    end
endmodule
bind tws_serializer tws_serializer_monitor tws_serializer_monitor_i (.*);
